// >>> afrh_pkg.sv
// package for the fault and reset handler: timing counts, modes, states
// assumes a 125 MHz core clock on both ends
package afrh_pkg;
  localparam int unsigned CLK_MHZ = 125;
  // controller wait after the fault falling edge, in microseconds
  localparam int unsigned RESET_HOLD_US = 4000;
  localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_US * CLK_MHZ;
  // ramp down length in cycles before the stage goes high impedance
  localparam int unsigned RAMP_CYC = 256;
  // overload counter limit
  localparam int unsigned OVL_MAX = 255;
  localparam int unsigned OVL_W = 8;
  // least wait after a fault before the controller pulls reset low
  localparam int unsigned RESET_LOW_CYC = 16;
  // output configuration
  localparam logic [1:0] CFG_BTL = 2'h0;
  localparam logic [1:0] CFG_PBTL = 2'h1;
  localparam logic [1:0] CFG_SE = 2'h2;
  typedef enum logic [2:0]
  {
    AFRH_RUN = 3'h1,
    AFRH_RAMP = 3'h2,
    AFRH_HOLD = 3'h4
  } afrh_state_t;
  typedef enum logic [3:0]
  {
    AFRH_C_IDLE = 4'h1,
    AFRH_C_WAIT = 4'h2,
    AFRH_C_LOW = 4'h4,
    AFRH_C_COOL = 4'h8
  } afrh_cstate_t;
endpackage

// >>> afrh_if.sv
// link between the power stage fault logic and the system controller
// assumes both ends share core_clk; pins are plain levels here
`timescale 1ns/1ns
`default_nettype none
interface afrh_if;
  logic fault_n;
  logic temp_warning_n;
  logic reset_n;
  modport dev
  (
    output fault_n,
    output temp_warning_n,
    input reset_n
  );
  modport ctl
  (
    input fault_n,
    input temp_warning_n,
    output reset_n
  );
endinterface
`default_nettype wire

// >>> afrh_device.sv
// device end: sorts protection events, drives fault and warning pins,
// runs the reset ramp down, pulldowns and restart.
// assumes event inputs are synchronous to core_clk; reset_n comes from
// the controller on the same clock.
// Function
// - global fault stops all channels, fault low
// - latched global fault held until reset toggled
// - channel fault stops only affected channel
// - reset low forces fault pin high
// - controller releases reset only when warning inactive
// - controller lowers volume on temperature warning
// - supply undervoltages are global, self clearing
// - thermal warning only flags, self clears
// - lost switching clock in slave mode: high impedance, unreported
// - reset low starts controlled ramp down
// - high impedance only after ramp completes
// - pulldowns on during reset, all configurations
// - weak bootstrap pulldowns during reset in bridge modes
// - reset rising edge clears latched overload
// - controller waits 4 ms after fault before release
// - bootstrap undervoltage: half bridge off, unlatched, unreported
// - overcurrent flips half bridge until next frame
// - overload counter saturation latches channel off
// - thermal shutdown: all off, fault low, latched
`timescale 1ns/1ns
`default_nettype none
module afrh_device #(
  parameter int unsigned RAMP_CYC = afrh_pkg::RAMP_CYC,
  parameter int unsigned OVL_MAX = afrh_pkg::OVL_MAX
)
(
  input wire logic core_clk,
  input wire logic srst,
  afrh_if.dev link,
  input wire logic [1:0] out_cfg,
  input wire logic slave_mode,
  input wire logic clk_lost,
  input wire logic frame_start,
  input wire logic uv_power_stage,
  input wire logic uv_main,
  input wire logic uv_analog,
  input wire logic por_digital,
  input wire logic temp_warn_in,
  input wire logic temp_shutdown_in,
  input wire logic latched_oc_mode,
  input wire logic [3:0] overcurrent,
  input wire logic [3:0] boot_uv,
  output logic [3:0] hb_enable,
  output logic [3:0] hb_flip,
  output logic ramp_active,
  output logic pulldown_en,
  output logic weak_pulldown_en
);
  localparam int unsigned OW = afrh_pkg::OVL_W;
  typedef struct packed {
    afrh_pkg::afrh_state_t st;
    logic rst_q;
    logic glob_latch;
    logic [3:0] ch_latch;
    logic [3:0] flip;
    logic [3:0][OW-1:0] ovl;
    logic [OW-1:0] ramp;
    logic fault_n;
    logic warn_n;
    logic [3:0] hb_en;
    logic pd;
    logic wpd;
    logic ramp_on;
    logic [3:0] flip_q;
  } afrh_dev_t;
  afrh_dev_t s_ff;
  afrh_dev_t nxt_s;
  // expands a half-bridge local error into the half bridges it turns off
  function automatic logic [3:0] afrh_spread(input logic [3:0] err, input logic [1:0] cfg);
    logic [3:0] r;
    r = err;
    if (cfg == afrh_pkg::CFG_PBTL)
    begin
      r = (|err) ? 4'hF : 4'h0;
    end
    else if (cfg == afrh_pkg::CFG_BTL)
    begin
      r = {{2{|err[3:2]}}, {2{|err[1:0]}}};
    end
    return r;
  endfunction
  logic self_glob;
  logic [3:0] ch_err;
  assign self_glob = uv_power_stage | uv_main | uv_analog | por_digital;
  // next state of the whole handler
  always_comb
  begin
    nxt_s = s_ff;
    ch_err = 4'h0;
    nxt_s.rst_q = link.reset_n;
    // flips clear at each frame, set by overcurrent
    for (int i = 0; i < 4; i++)
    begin
      if (frame_start)
      begin
        nxt_s.flip[i] = 1'b0;
      end
      if (!latched_oc_mode && overcurrent[i])
      begin
        nxt_s.flip[i] = 1'b1;
      end
      // a frame counts as hit if any overcurrent flipped it
      if (frame_start)
      begin
        if ((overcurrent[i] | s_ff.flip[i]) && s_ff.ovl[i] != OW'(OVL_MAX))
        begin
          nxt_s.ovl[i] = s_ff.ovl[i] + OW'(1);
        end
        else if (!(overcurrent[i] | s_ff.flip[i]) && s_ff.ovl[i] != '0)
        begin
          nxt_s.ovl[i] = s_ff.ovl[i] - OW'(1);
        end
      end
      ch_err[i] = (s_ff.ovl[i] == OW'(OVL_MAX)) | (latched_oc_mode & overcurrent[i]);
    end
    nxt_s.ch_latch = s_ff.ch_latch | afrh_spread(ch_err, out_cfg);
    if (temp_shutdown_in)
    begin
      nxt_s.glob_latch = 1'b1;
    end
    case (s_ff.st)
      afrh_pkg::AFRH_RUN:
      begin
        if (!link.reset_n)
        begin
          nxt_s.st = afrh_pkg::AFRH_RAMP;
          nxt_s.ramp = '0;
        end
      end
      afrh_pkg::AFRH_RAMP:
      begin
        nxt_s.ramp = s_ff.ramp + OW'(1);
        if (s_ff.ramp == OW'(RAMP_CYC - 1))
        begin
          nxt_s.st = afrh_pkg::AFRH_HOLD;
        end
      end
      afrh_pkg::AFRH_HOLD:
      begin
        if (link.reset_n && !s_ff.rst_q)
        begin
          // rising edge clears latched faults and restarts
          nxt_s.st = afrh_pkg::AFRH_RUN;
          nxt_s.glob_latch = temp_shutdown_in;
          // a new event in the clearing cycle still sets
          nxt_s.ch_latch = afrh_spread(overcurrent & {4{latched_oc_mode}}, out_cfg);
          nxt_s.flip = overcurrent & {4{!latched_oc_mode}};
          nxt_s.ovl = '0;
        end
      end
      default:
      begin
        nxt_s.st = afrh_pkg::AFRH_HOLD;
      end
    endcase
    if (por_digital)
    begin
      nxt_s.ovl = '0; // power-on clears overload counters
    end
    // pin and stage outputs
    nxt_s.ramp_on = (nxt_s.st == afrh_pkg::AFRH_RAMP);
    nxt_s.pd = (nxt_s.st != afrh_pkg::AFRH_RUN) && !link.reset_n;
    nxt_s.wpd = nxt_s.pd && (out_cfg != afrh_pkg::CFG_SE);
    nxt_s.warn_n = !temp_warn_in;
    if (!link.reset_n)
    begin
      nxt_s.fault_n = 1'b1;
    end
    else
    begin
      nxt_s.fault_n = !(self_glob | nxt_s.glob_latch | (|nxt_s.ch_latch));
    end
    if (nxt_s.st == afrh_pkg::AFRH_HOLD || self_glob || nxt_s.glob_latch
        || (slave_mode && clk_lost))
    begin
      nxt_s.hb_en = 4'h0;
    end
    else
    begin
      nxt_s.hb_en = ~(nxt_s.ch_latch | boot_uv);
    end
    nxt_s.flip_q = nxt_s.flip & nxt_s.hb_en;
  end
  // state register
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s_ff <= '{st: afrh_pkg::AFRH_HOLD, rst_q: 1'b0, glob_latch: 1'b0,
                ch_latch: 4'h0, flip: 4'h0, ovl: '0, ramp: '0, fault_n: 1'b1,
                warn_n: 1'b1, hb_en: 4'h0, pd: 1'b1, wpd: 1'b0, ramp_on: 1'b0,
                flip_q: 4'h0};
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end
  assign link.fault_n = s_ff.fault_n;
  assign link.temp_warning_n = s_ff.warn_n;
  assign hb_enable = s_ff.hb_en;
  assign hb_flip = s_ff.flip_q;
  assign ramp_active = s_ff.ramp_on;
  assign pulldown_en = s_ff.pd;
  assign weak_pulldown_en = s_ff.wpd;
endmodule
`default_nettype wire

// >>> afrh_ctrl.sv
// controller end: watches fault and warning pins, drives reset_n
// assumes the device pins arrive on core_clk through the interface
`timescale 1ns/1ns
`default_nettype none
module afrh_ctrl #(
  parameter int unsigned RESET_HOLD_CYC = afrh_pkg::RESET_HOLD_CYC,
  parameter int unsigned RESET_LOW_CYC = afrh_pkg::RESET_LOW_CYC
)
(
  input wire logic core_clk,
  input wire logic srst,
  afrh_if.ctl link,
  input wire logic auto_recover,
  output logic volume_down,
  output logic fault_seen,
  output logic busy
);
  typedef struct packed {
    afrh_pkg::afrh_cstate_t st;
    logic [31:0] cnt;
    logic rst_n;
    logic vol_dn;
    logic seen;
    logic busy;
  } afrh_ctl_t;
  afrh_ctl_t s_ff;
  afrh_ctl_t nxt_s;
  // recovery sequence
  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.vol_dn = !link.temp_warning_n;
    case (s_ff.st)
      afrh_pkg::AFRH_C_IDLE:
      begin
        nxt_s.rst_n = 1'b1;
        if (!link.fault_n)
        begin
          nxt_s.seen = 1'b1;
          nxt_s.cnt = '0;
          nxt_s.st = afrh_pkg::AFRH_C_WAIT;
        end
      end
      afrh_pkg::AFRH_C_WAIT:
      begin
        nxt_s.cnt = s_ff.cnt + 32'h1;
        if (s_ff.cnt >= 32'(RESET_LOW_CYC) && auto_recover)
        begin
          nxt_s.rst_n = 1'b0; // wait over with auto_recover set; pull reset low
          nxt_s.st = afrh_pkg::AFRH_C_LOW;
        end
      end
      afrh_pkg::AFRH_C_LOW:
      begin
        nxt_s.cnt = s_ff.cnt + 32'h1;
        if (s_ff.cnt >= 32'(RESET_HOLD_CYC))
        begin
          nxt_s.st = afrh_pkg::AFRH_C_COOL;
        end
      end
      afrh_pkg::AFRH_C_COOL:
      begin
        if (link.temp_warning_n)
        begin
          nxt_s.rst_n = 1'b1;
          nxt_s.seen = 1'b0;
          nxt_s.st = afrh_pkg::AFRH_C_IDLE;
        end
      end
      default:
      begin
        nxt_s.st = afrh_pkg::AFRH_C_IDLE;
      end
    endcase
    nxt_s.busy = (nxt_s.st != afrh_pkg::AFRH_C_IDLE);
  end
  // state register; reset released once warning clear
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s_ff <= '{st: afrh_pkg::AFRH_C_COOL, cnt: 32'h0, rst_n: 1'b0,
                vol_dn: 1'b0, seen: 1'b0, busy: 1'b1};
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end
  assign link.reset_n = s_ff.rst_n;
  assign volume_down = s_ff.vol_dn;
  assign fault_seen = s_ff.seen;
  assign busy = s_ff.busy;
endmodule
`default_nettype wire

// >>> afrh_properties.sv
// checker on the fault link and the device stage outputs
// assumes one core_clk domain, a device ramp of 8 cycles and a
// controller hold of 50 cycles
`timescale 1ns/1ns
`default_nettype none
module afrh_properties
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic fault_n,
  input wire logic temp_warning_n,
  input wire logic reset_n,
  input wire logic temp_warn_in,
  input wire logic temp_shutdown_in,
  input wire logic uv_main,
  input wire logic [1:0] out_cfg,
  input wire logic [3:0] hb_enable,
  input wire logic ramp_active,
  input wire logic pulldown_en,
  input wire logic weak_pulldown_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  localparam int unsigned HOLD_CYC = 50;
  logic fault_q_ff;
  logic [15:0] since_fault_ff;
  // cycles since the fault pin last fell, held at the top
  always_ff @(posedge core_clk)
  begin
    fault_q_ff <= fault_n;
    if (srst)
    begin
      since_fault_ff <= 16'hFFFF;
    end
    else if (fault_q_ff && !fault_n)
    begin
      since_fault_ff <= 16'h0;
    end
    else if (since_fault_ff != 16'hFFFF)
    begin
      since_fault_ff <= since_fault_ff + 16'h1;
    end
  end
  // fault pin, warning pin and stop paths
  rst_fault_a: assert property (!reset_n |=> fault_n)
    else $error("fault pin low while reset held");
  warn_follow_a: assert property (1'b1 |=> temp_warning_n == !$past(temp_warn_in))
    else $error("warning pin does not follow warning input");
  uv_stop_a: assert property (uv_main && reset_n |=> !fault_n && hb_enable == 4'h0)
    else $error("undervoltage did not stop stage");
  hot_stop_a: assert property (temp_shutdown_in && reset_n |=> !fault_n && hb_enable == 4'h0)
    else $error("thermal shutdown did not stop stage");
  // reset ramp, high impedance, pulldowns and reset release
  ramp_start_a: assert property ($fell(reset_n) |=> ramp_active)
    else $error("reset low did not start ramp");
  ramp_len_a: assert property ($rose(ramp_active) |-> ramp_active [*8] ##1 !ramp_active)
    else $error("ramp length wrong");
  ramp_hiz_a: assert property ($fell(ramp_active) |-> hb_enable == 4'h0)
    else $error("stage still on after ramp");
  pull_on_a: assert property (!reset_n |=> pulldown_en)
    else $error("pulldown off during reset");
  weak_pull_a: assert property (!reset_n && out_cfg != afrh_pkg::CFG_SE |=> weak_pulldown_en)
    else $error("weak pulldown off in bridge mode");
  cool_release_a: assert property ($rose(reset_n) |-> $past(temp_warning_n))
    else $error("reset released while warning active");
  hold_wait_a: assert property ($rose(reset_n) |-> since_fault_ff >= 16'(HOLD_CYC))
    else $error("reset released too soon after fault");
  // main scenarios seen
  cover property (!fault_n ##1 !reset_n);
  cover property ($rose(reset_n));
  cover property (!temp_warning_n);
endmodule
`default_nettype wire

// >>> testbench.sv
// self-checking bench joining device and controller ends
// assumes short counts: ramp 8, hold 50, overload 4
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] cfg = 2'h0;
  logic slave = 1'b0, lost = 1'b0, fs = 1'b0, tw = 1'b0, ts = 1'b0, loc = 1'b0, auto = 1'b1;
  logic [3:0] uv = 4'h0, oc = 4'h0, buv = 4'h0;
  logic [3:0] hb, flip;
  logic ramp, pd, wpd, vol, busy, seen;
  int n_fail = 0, tests_run = 0;
  afrh_if link();
  afrh_device #(.RAMP_CYC(8), .OVL_MAX(4)) u_afrh_device (.core_clk(core_clk), .srst(srst),
    .link(link), .out_cfg(cfg), .slave_mode(slave), .clk_lost(lost), .frame_start(fs),
    .uv_power_stage(uv[0]), .uv_main(uv[1]), .uv_analog(uv[2]), .por_digital(uv[3]),
    .temp_warn_in(tw), .temp_shutdown_in(ts), .latched_oc_mode(loc), .overcurrent(oc),
    .boot_uv(buv), .hb_enable(hb), .hb_flip(flip), .ramp_active(ramp), .pulldown_en(pd),
    .weak_pulldown_en(wpd));
  afrh_ctrl #(.RESET_HOLD_CYC(50), .RESET_LOW_CYC(16)) u_afrh_ctrl (.core_clk(core_clk),
    .srst(srst), .link(link), .auto_recover(auto), .volume_down(vol), .fault_seen(seen),
    .busy(busy));
  afrh_properties u_afrh_properties (.core_clk(core_clk), .srst(srst),
    .fault_n(link.fault_n), .temp_warning_n(link.temp_warning_n), .reset_n(link.reset_n),
    .temp_warn_in(tw), .temp_shutdown_in(ts), .uv_main(uv[1]), .out_cfg(cfg),
    .hb_enable(hb), .ramp_active(ramp), .pulldown_en(pd), .weak_pulldown_en(wpd));
  // 125 MHz clock
  initial
  begin
    forever #4 core_clk = ~core_clk;
  end
  // random frame pulses
  always @(negedge core_clk) fs <= ($urandom_range(3) == 0);
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait for a reset pin level
  task automatic wait_rst(input logic lvl);
    int i;
    for (i = 0; i < 400 && link.reset_n !== lvl; i++)
      @(negedge core_clk);
    if (i == 400)
    begin
      n_fail++;
      finish_test();
    end
  endtask
  // reset cycle run by the controller after a fault
  task automatic recover(input logic hot);
    wait_rst(1'b0);
    @(negedge core_clk);
    chk({2'h0, link.fault_n, ramp}, 4'h3);
    chk({2'h0, busy, seen}, 4'h3);
    repeat (8) @(negedge core_clk);
    chk(hb, 4'h0);
    chk({2'h0, pd, wpd}, {3'h1, cfg != afrh_pkg::CFG_SE});
    // warning still active: reset must stay low past the hold
    if (hot)
    begin
      repeat (60) @(negedge core_clk);
      chk(4'(link.reset_n), 4'h0);
      tw = 1'b0;
    end
    wait_rst(1'b1);
    repeat (2) @(negedge core_clk);
    chk(hb, 4'hF);
    chk({2'h0, busy, seen}, 4'h0);
  endtask
  // half bridges stopped by a channel fault
  function automatic logic [3:0] off_mask(input logic [1:0] c, input int h);
    if (c == afrh_pkg::CFG_PBTL)
      return 4'hF;
    if (c == afrh_pkg::CFG_SE)
      return 4'h1 << h;
    return (h < 2) ? 4'h3 : 4'hC;
  endfunction
  initial
  begin
    int i, k, h;
    void'($urandom(32'h6f48));
    repeat (6) @(negedge core_clk);
    srst = 1'b0;
    wait_rst(1'b1);
    repeat (2) @(negedge core_clk);
    // latched thermal shutdown
    ts = 1'b1;
    tw = 1'b1;
    repeat (2) @(negedge core_clk);
    chk({link.fault_n, 3'h0}, 4'h0);
    chk(hb, 4'h0);
    ts = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(4'(link.fault_n), 4'h0);
    recover(1'b1);
    // latched channel overcurrent, each mode then random
    loc = 1'b1;
    for (k = 0; k < 6; k++)
    begin
      cfg = (k < 3) ? 2'(k) : 2'($urandom_range(2));
      h = $urandom_range(3);
      @(negedge core_clk);
      oc = 4'h1 << h;
      @(negedge core_clk);
      oc = 4'h0;
      for (i = 0; i < 20 && hb === 4'hF; i++)
        @(negedge core_clk);
      chk(hb, ~off_mask(cfg, h));
      recover(1'b0);
    end
    // cycle by cycle limiting, then overload counter saturation
    loc = 1'b0;
    cfg = 2'($urandom_range(2));
    h = $urandom_range(3);
    oc = 4'h1 << h;
    @(negedge core_clk);
    chk(flip, 4'h1 << h);
    oc = 4'h0;
    for (i = 0; i < 50 && flip !== 4'h0; i++)
      @(negedge core_clk);
    chk(flip, 4'h0);
    oc = 4'h1 << h;
    for (i = 0; i < 200 && hb === 4'hF; i++)
      @(negedge core_clk);
    chk(hb, ~off_mask(cfg, h));
    oc = 4'h0;
    recover(1'b0);
    // self clearing faults with no reset from the controller
    auto = 1'b0;
    for (k = 0; k < 4; k++)
    begin
      uv = 4'h1 << k;
      repeat (2) @(negedge core_clk);
      chk({link.fault_n, hb[2:0]}, 4'h0);
      uv = 4'h0;
      buv = 4'h1 << k;
      repeat (2) @(negedge core_clk);
      chk({hb[k], link.fault_n, 2'h0}, 4'h4);
      buv = 4'h0;
      slave = 1'b1;
      lost = 1'b1;
      repeat (2) @(negedge core_clk);
      chk({link.fault_n, hb[2:0]}, 4'h8);
      lost = 1'b0;
      tw = 1'b1;
      repeat (2) @(negedge core_clk);
      chk({hb[1:0], link.temp_warning_n, vol}, 4'hD);
      tw = 1'b0;
      slave = 1'b0;
    end
    finish_test();
  end
endmodule
`default_nettype wire
